// ===== dv/scan_cmd_sva.sv
`timescale 1ns/1ps
`default_nettype none

module scan_cmd_sva (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire scan_cmd_pkg::motor_ctrl_t motor,
    input wire logic scanEnable,
    input wire logic pointerReset,
    input wire logic feedDone,
    input wire logic refreshEnable,
    input wire logic standbyActive,
    input wire logic engineHeld,
    input wire logic softResetPulse,
    input wire scan_cmd_pkg::clock_ticks_t ticks
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_idle_phases: assert property (!motor.run |-> motor.phasesLow)
        else $error("phases driven while motor stopped");
    a_ptr_before_scan: assert property ($rose(scanEnable) |-> $past(pointerReset))
        else $error("scan began without pointer reset");
    a_ptr_single: assert property (pointerReset |=> !pointerReset)
        else $error("pointer reset longer than one cycle");
    a_feed_done_stop: assert property (feedDone |-> !motor.run)
        else $error("motor runs after programmed feed ended");
    a_standby_refresh: assert property (standbyActive && $past(standbyActive) |-> !refreshEnable)
        else $error("refresh during standby");
    a_standby_ticks: assert property (standbyActive [*3] |-> ticks == '0)
        else $error("clock ticks during standby");
    a_held_refresh: assert property (engineHeld && $past(engineHeld) |-> !refreshEnable)
        else $error("refresh during soft reset");
    a_soft_pulse: assert property (softResetPulse |-> $past(engineHeld) || $past(engineHeld, 2))
        else $error("soft reset pulse without held engine");
    a_adc_after_mclk: assert property (ticks.adcTick |-> $past(ticks.mclkTick))
        else $error("converter tick without master tick");

    c_scan: cover property (pointerReset);
    c_done: cover property ($rose(feedDone));
    c_soft: cover property (softResetPulse);
    c_adc: cover property (ticks.adcTick);
endmodule

bind scan_command_and_clock_divider scan_cmd_sva scan_cmd_sva_inst (.core_clk, .rst_n,
    .motor, .scanEnable, .pointerReset, .feedDone, .refreshEnable, .standbyActive,
    .engineHeld, .softResetPulse, .ticks);

`default_nettype wire

// ===== dv/scan_command_and_clock_divider_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "scan_cmd_regs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end

module scan_command_and_clock_divider_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic [15:0] programmedLines = 16'h0;
    logic feedLineTick = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    scan_cmd_pkg::motor_ctrl_t motor;
    scan_cmd_pkg::clock_ticks_t ticks;
    logic scanEnable, pointerReset, feedDone, refreshEnable, standbyActive, engineHeld;
    logic softResetPulse;
    logic pulseSeen = 1'b0;
    logic ptrSeen = 1'b0;
    int error_cnt = 0, checked = 0, cycles = 0;
    // Expected status byte per command code: refresh, feed done, scan enable, run, reverse and state fields.
    logic [7:0] stat [8] = '{8'h80, 8'h91, 8'h9a, 8'hb3, 8'h80, 8'h94, 8'h9d, 8'h80};

    scan_command_and_clock_divider scan_command_and_clock_divider_inst (.core_clk, .rst_n,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .programmedLines, .feedLineTick, .motor, .scanEnable, .pointerReset, .feedDone,
        .refreshEnable, .standbyActive, .engineHeld, .softResetPulse, .ticks);

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    // The hang limit is far above the few hundred cycles the sequence needs.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (softResetPulse === 1'b1) pulseSeen <= 1'b1;
        if (pointerReset === 1'b1) ptrSeen <= 1'b1;
        if (cycles == 8000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK("bresp", er, bresp)
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        `CHK("rresp", er, rresp)
        `CHK("rdata", {24'h0, e}, rdata)
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Cycles spanned by n tick intervals, starting at a tick.
    task automatic span(input bit adc, input int n, input int e);
        int c;
        int k;
        c = 0;
        k = 0;
        do @(posedge core_clk); while ((adc ? ticks.adcTick : ticks.mclkTick) !== 1'b1);
        while (k < n) begin
            @(posedge core_clk);
            c++;
            if ((adc ? ticks.adcTick : ticks.mclkTick) === 1'b1) k++;
        end
        `CHK("tick span", e, c)
    endtask

    initial begin
        waitc(8);
        rst_n <= 1'b1;
        waitc(2);
        rd(`CMD_REG_ADDR, 8'h00, `RESP_OKAY);
        rd(`STATUS_REG_ADDR, 8'h80, `RESP_OKAY);
        rd(8'h04, 8'h00, `RESP_SLVERR);
        wr(8'h04, 8'h5a, `RESP_SLVERR);
        programmedLines <= 16'h0005;
        for (int i = 0; i < 8; i++) begin
            wr(`CMD_REG_ADDR, 8'(i), `RESP_OKAY);
            waitc(6);
            rd(`STATUS_REG_ADDR, stat[i], `RESP_OKAY);
            `CHK("motor", {stat[i][4], stat[i][3], ~stat[i][4]}, motor)
            wr(`CMD_REG_ADDR, 8'h00, `RESP_OKAY);
        end
        `CHK("pointer", 1'b1, ptrSeen)
        programmedLines <= 16'h0003;
        wr(`CMD_REG_ADDR, 8'h05, `RESP_OKAY);
        waitc(4);
        for (int k = 0; k < 3; k++) begin
            feedLineTick <= 1'b1;
            @(posedge core_clk);
            feedLineTick <= 1'b0;
            waitc(2);
            rd(`STATUS_REG_ADDR, (k == 2) ? 8'hc6 : 8'h94, `RESP_OKAY);
        end
        `CHK("feedDone", 1'b1, feedDone)
        `CHK("motor", 3'h1, motor)
        wr(`CMD_REG_ADDR, 8'h00, `RESP_OKAY);
        programmedLines <= 16'h0000;
        wr(`CMD_REG_ADDR, 8'h06, `RESP_OKAY);
        waitc(5);
        rd(`STATUS_REG_ADDR, 8'hc6, `RESP_OKAY);
        wr(`CMD_REG_ADDR, 8'h10, `RESP_OKAY);
        waitc(4);
        `CHK("standby", 1'b1, standbyActive)
        rd(`STATUS_REG_ADDR, 8'h00, `RESP_OKAY);
        wr(`CMD_REG_ADDR, 8'h00, `RESP_OKAY);
        waitc(4);
        `CHK("refresh", 1'b1, refreshEnable)
        wr(`CMD_REG_ADDR, 8'h21, `RESP_OKAY);
        waitc(4);
        `CHK("held", 1'b1, engineHeld)
        `CHK("refresh", 1'b0, refreshEnable)
        wr(`CMD_REG_ADDR, 8'h00, `RESP_OKAY);
        waitc(4);
        `CHK("pulse", 1'b1, pulseSeen)
        rd(`STATUS_REG_ADDR, 8'h80, `RESP_OKAY);
        span(1'b0, 4, 4);
        wr(`DIV_REG_ADDR, 8'h06, `RESP_OKAY);
        rd(`DIV_REG_ADDR, 8'h06, `RESP_OKAY);
        span(1'b0, 2, 8);
        span(1'b1, 1, 32);
        wr(`DIV_REG_ADDR, 8'h01, `RESP_OKAY);
        // A shrunk ratio leaves the accumulator high, so it ticks every cycle until drained.
        waitc(10);
        span(1'b0, 2, 3);
        wr(`DIV_REG_ADDR, 8'h3f, `RESP_OKAY);
        span(1'b0, 2, 65);
        report_and_stop();
    end
endmodule

`default_nettype wire

// ===== logic/clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "scan_cmd_regs.svh"

module clock_divider (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [5:0] ratioField,
    output scan_cmd_pkg::clock_ticks_t ticks
);

    // The ratio is kept in half steps, so the half-integer ratios need no second clock.
    logic [7:0] accReg;
    logic [2:0] adcCountReg;
    logic mclkTickReg;
    logic adcTickReg;
    logic [7:0] halfSteps;
    logic [7:0] accSum;

    // Each tick has a single owner process; the struct only bundles them for the port.
    assign ticks = '{mclkTick: mclkTickReg, adcTick: adcTickReg};
    assign halfSteps = {2'h0, ratioField} + 8'h02;
    assign accSum = accReg + 8'h02;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            accReg <= 8'h00;
            mclkTickReg <= 1'b0;
        end else if (!enable) begin
            accReg <= 8'h00;
            mclkTickReg <= 1'b0;
        end else if (accSum >= halfSteps) begin
            accReg <= accSum - halfSteps;
            mclkTickReg <= 1'b1;
        end else begin
            accReg <= accSum;
            mclkTickReg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            adcCountReg <= 3'h0;
            adcTickReg <= 1'b0;
        end else if (!enable) begin
            adcCountReg <= 3'h0;
            adcTickReg <= 1'b0;
        end else if (mclkTickReg) begin
            adcCountReg <= adcCountReg + 3'h1;
            adcTickReg <= (adcCountReg == `ADC_PER_MCLK);
        end else begin
            adcTickReg <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== logic/scan_cmd_pkg.sv
`default_nettype none
package scan_cmd_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FEED_FWD,
        ST_FEED_REV,
        ST_SCAN,
        ST_PROG_FWD,
        ST_PROG_REV,
        ST_PROG_DONE
    } engine_state_t;

    typedef struct packed {
        logic run;
        logic reverse;
        logic phasesLow;
    } motor_ctrl_t;

    typedef struct packed {
        logic mclkTick;
        logic adcTick;
    } clock_ticks_t;

endpackage
`default_nettype wire

// ===== logic/scan_cmd_regs.svh
// Summary of operation
// - Idle code stops motor, finishes line.
// - Code 010 feeds motor backward continuously.
// - Code 011 resets pointers, then scans.
// - Code 101 feeds forward programmed lines.
// - Code 110 feeds backward programmed lines.
// - Standby bit one enters low power.
// - Standby stops external DRAM refresh.
// - Reset bit one then zero resets.
// - Soft reset halts external DRAM refresh.
// - Master clock divided; converter clock eighth.
`ifndef SCAN_CMD_REGS_SVH
`define SCAN_CMD_REGS_SVH

`define CMD_REG_INDEX 8'h07
`define DIV_REG_INDEX 8'h08
`define STATUS_REG_INDEX 8'h10
`define CMD_REG_ADDR 8'h1c
`define DIV_REG_ADDR 8'h20
`define STATUS_REG_ADDR 8'h40

`define CMD_RESET 8'h00
`define DIV_RESET 8'h00

`define CMD_CODE_LSB 0
`define CMD_CODE_MSB 2
`define CMD_STANDBY_BIT 4
`define CMD_SOFT_RESET_BIT 5
`define DIV_FIELD_LSB 0
`define DIV_FIELD_MSB 5

`define CODE_IDLE 3'h0
`define CODE_FEED_FWD 3'h1
`define CODE_FEED_REV 3'h2
`define CODE_START_SCAN 3'h3
`define CODE_PROG_FWD 3'h5
`define CODE_PROG_REV 3'h6

`define XTAL_HZ 48000000
`define ADC_PER_MCLK 3'h7

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== logic/scan_command_and_clock_divider.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scan_cmd_regs.svh"

module scan_command_and_clock_divider #(
    parameter int ADDR_W = 8,
    parameter int LINE_W = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [LINE_W-1:0] programmedLines,
    input wire logic feedLineTick,
    output scan_cmd_pkg::motor_ctrl_t motor,
    output logic scanEnable,
    output logic pointerReset,
    output logic feedDone,
    output logic refreshEnable,
    output logic standbyActive,
    output logic engineHeld,
    output logic softResetPulse,
    output scan_cmd_pkg::clock_ticks_t ticks
);

    // Decodes a byte address into a register select: 0 none, 1 command, 2 divider,
    // 3 status.
    function automatic logic [1:0] regSel(input logic [ADDR_W-1:0] addr);
        logic [1:0] sel;
        sel = 2'h0;
        if (addr == ADDR_W'(`CMD_REG_ADDR)) begin
            sel = 2'h1;
        end else if (addr == ADDR_W'(`DIV_REG_ADDR)) begin
            sel = 2'h2;
        end else if (addr == ADDR_W'(`STATUS_REG_ADDR)) begin
            sel = 2'h3;
        end
        return sel;
    endfunction

    logic [7:0] cmdReg;
    logic [7:0] divReg;
    logic [ADDR_W-1:0] wAddrReg;
    logic [31:0] wDataReg;
    logic [3:0] wStrbReg;
    logic haveAddrReg;
    logic haveDataReg;
    logic cmdWritePulseReg;
    logic [LINE_W-1:0] lineCountReg;
    scan_cmd_pkg::engine_state_t stateReg;
    scan_cmd_pkg::engine_state_t stateNext;

    logic doWrite;
    logic [1:0] wSel;
    logic [1:0] rSel;
    logic [2:0] cmdCode;
    logic standbyBit;
    logic resetBit;
    logic halted;

    assign doWrite = haveAddrReg && haveDataReg && !bvalid;
    assign wSel = regSel(wAddrReg);
    assign rSel = regSel(araddr);
    assign cmdCode = cmdReg[`CMD_CODE_MSB:`CMD_CODE_LSB];
    assign standbyBit = cmdReg[`CMD_STANDBY_BIT];
    assign resetBit = cmdReg[`CMD_SOFT_RESET_BIT];
    assign halted = standbyBit || resetBit;

    // Address and data are captured separately, so the master may offer them in either order.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            haveAddrReg <= 1'b0;
            wAddrReg <= '0;
            awready <= 1'b0;
        end else if (awvalid && awready) begin
            haveAddrReg <= 1'b1;
            wAddrReg <= awaddr;
            awready <= 1'b0;
        end else if (doWrite) begin
            haveAddrReg <= 1'b0;
            awready <= 1'b0;
        end else begin
            awready <= !haveAddrReg && !bvalid;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            haveDataReg <= 1'b0;
            wDataReg <= 32'h0000_0000;
            wStrbReg <= 4'h0;
            wready <= 1'b0;
        end else if (wvalid && wready) begin
            haveDataReg <= 1'b1;
            wDataReg <= wdata;
            wStrbReg <= wstrb;
            wready <= 1'b0;
        end else if (doWrite) begin
            haveDataReg <= 1'b0;
            wready <= 1'b0;
        end else begin
            wready <= !haveDataReg && !bvalid;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= (wSel == 2'h1 || wSel == 2'h2) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Only byte lane 0 carries register bits; other lanes are accepted and dropped.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdReg <= `CMD_RESET;
            cmdWritePulseReg <= 1'b0;
        end else if (doWrite && wSel == 2'h1 && wStrbReg[0]) begin
            cmdReg <= wDataReg[7:0];
            cmdWritePulseReg <= 1'b1;
        end else begin
            cmdWritePulseReg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            divReg <= `DIV_RESET;
        end else if (doWrite && wSel == 2'h2 && wStrbReg[0]) begin
            divReg <= wDataReg[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= (rSel == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
            case (rSel)
                2'h1: begin
                    rdata <= {24'h00_0000, cmdReg};
                end
                2'h2: begin
                    rdata <= {24'h00_0000, divReg};
                end
                2'h3: begin
                    rdata <= {24'h00_0000, refreshEnable, feedDone, scanEnable,
                        motor.run, motor.reverse, stateReg};
                end
                default: begin
                    rdata <= 32'h0000_0000;
                end
            endcase
        end else if (rvalid) begin
            if (rready) begin
                rvalid <= 1'b0;
            end
        end else begin
            arready <= 1'b1;
        end
    end

    // A code is acted on only in the cycle after it is written; software need not pass through idle
    // between commands, as a repeated write of code 101 or 110 still reloads the line count and starts afresh.
    always_comb begin
        stateNext = stateReg;
        if (halted) begin
            stateNext = scan_cmd_pkg::ST_IDLE;
        end else if (cmdWritePulseReg) begin
            case (cmdCode)
                `CODE_FEED_FWD: begin
                    stateNext = scan_cmd_pkg::ST_FEED_FWD;
                end
                `CODE_FEED_REV: begin
                    stateNext = scan_cmd_pkg::ST_FEED_REV;
                end
                `CODE_START_SCAN: begin
                    stateNext = scan_cmd_pkg::ST_SCAN;
                end
                `CODE_PROG_FWD: begin
                    stateNext = (programmedLines == '0) ? scan_cmd_pkg::ST_PROG_DONE
                        : scan_cmd_pkg::ST_PROG_FWD;
                end
                `CODE_PROG_REV: begin
                    stateNext = (programmedLines == '0) ? scan_cmd_pkg::ST_PROG_DONE
                        : scan_cmd_pkg::ST_PROG_REV;
                end
                default: begin
                    stateNext = scan_cmd_pkg::ST_IDLE;
                end
            endcase
        end else if ((stateReg == scan_cmd_pkg::ST_PROG_FWD
                || stateReg == scan_cmd_pkg::ST_PROG_REV)
                && feedLineTick && lineCountReg == LINE_W'(1)) begin
            stateNext = scan_cmd_pkg::ST_PROG_DONE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg <= scan_cmd_pkg::ST_IDLE;
        end else begin
            stateReg <= stateNext;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lineCountReg <= '0;
        end else if (cmdWritePulseReg) begin
            lineCountReg <= programmedLines;
        end else if (feedLineTick && lineCountReg != '0) begin
            lineCountReg <= lineCountReg - LINE_W'(1);
        end
    end

    // Phases go low as soon as motion ends; the scan engine sees scanEnable fall and is left
    // to finish the line it is on.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            motor <= '{run: 1'b0, reverse: 1'b0, phasesLow: 1'b1};
        end else begin
            case (stateNext)
                scan_cmd_pkg::ST_FEED_FWD, scan_cmd_pkg::ST_PROG_FWD: begin
                    motor <= '{run: 1'b1, reverse: 1'b0, phasesLow: 1'b0};
                end
                scan_cmd_pkg::ST_FEED_REV, scan_cmd_pkg::ST_PROG_REV: begin
                    motor <= '{run: 1'b1, reverse: 1'b1, phasesLow: 1'b0};
                end
                scan_cmd_pkg::ST_SCAN: begin
                    motor <= '{run: 1'b1, reverse: 1'b0, phasesLow: 1'b0};
                end
                default: begin
                    motor <= '{run: 1'b0, reverse: 1'b0, phasesLow: 1'b1};
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pointerReset <= 1'b0;
            scanEnable <= 1'b0;
        end else begin
            pointerReset <= stateNext == scan_cmd_pkg::ST_SCAN
                && stateReg != scan_cmd_pkg::ST_SCAN;
            scanEnable <= stateReg == scan_cmd_pkg::ST_SCAN
                && stateNext == scan_cmd_pkg::ST_SCAN;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            feedDone <= 1'b0;
        end else begin
            feedDone <= stateNext == scan_cmd_pkg::ST_PROG_DONE;
        end
    end

    // Refresh stops outright; a long standby or reset can lose the buffer contents.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            refreshEnable <= 1'b0;
            standbyActive <= 1'b0;
            engineHeld <= 1'b0;
        end else begin
            refreshEnable <= !halted;
            standbyActive <= standbyBit;
            engineHeld <= resetBit;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            softResetPulse <= 1'b0;
        end else begin
            softResetPulse <= cmdWritePulseReg && !resetBit && engineHeld;
        end
    end

    clock_divider divider (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .enable(!standbyBit),
        .ratioField(divReg[`DIV_FIELD_MSB:`DIV_FIELD_LSB]),
        .ticks(ticks)
    );

endmodule
`default_nettype wire
